// *** verilog/crceng_top.sv ***
// crceng_top: byte-stream crc engine with result port and auto flash walk
// assumes flash answers a read one cycle after a request, data valid then;
// all cpu strobes are one-cycle pulses on clk
//
// Contract
// [R1] 16-bit mode: msb-first, generator 0x1021
// [R2] 16-bit: xor byte into upper result byte
// [R3] 16-bit: eight left shifts, xor on msb
// [R4] 32-bit mode uses reflected algorithm
// [R5] 32-bit: xor byte into lowest byte
// [R6] 32-bit: eight right shifts, xor reflected
// [R7] preset to all zeros or ones
// [R8] width bit: 0 is 32, 1 is 16
// [R9] preset bit: 0 zeros, 1 ones
// [R10] preset command loads whole result
// [R11] each input byte write folds once
// [R12] software sets page, enable, then count
// [R13] control write in auto mode starts, stalls cpu
// [R14] 512 bytes per sector, consecutive sectors
// [R15] software clears enable before reading result
// [R16] result 32 bits or 16 bits wide
// [R17] pointer selects byte, increments per access
// [R18] result held unless preset, write, input
// [R19] separate bit-reverse register provided
// [R20] pointer map, 16-bit wraps upper codes
// [R21] bit-reverse reads back mirrored
`timescale 1ns/1ps
module crceng_top (
  // clock and reset
  input  wire logic                             clk,
  input  wire logic                             arst_n,
  // control register write
  input  wire logic                             ctrlWr,
  input  wire crceng_pkg::crceng_ctrl_type      ctrlData,
  // byte input register
  input  wire logic                             byteInWr,
  input  wire logic [7:0]                       byteIn,
  // result data port
  input  wire logic                             resultRd,
  input  wire logic                             resultWr,
  input  wire logic [7:0]                       resultWrData,
  // automatic flash control
  input  wire logic                             autoEnable,
  input  wire logic [crceng_pkg::PageW-1:0]     startPage,
  input  wire logic [crceng_pkg::CountW-1:0]    sectorCount,
  input  wire logic [7:0]                       flashData,
  // bit-reverse register
  input  wire logic                             revWr,
  input  wire logic [7:0]                       revData,
  // outputs
  output      logic [7:0]                       resultByte,
  output      logic [1:0]                       bytePtr,
  output      logic                             widthSel16,
  output      logic                             presetOnes,
  output      logic [31:0]                      result,
  output      logic [7:0]                       revOut,
  output      logic                             cpuStall,
  output      crceng_pkg::crceng_flash_req_type flashReq
);

  // fold one byte into the 16-bit result, msb first
  function automatic logic [15:0] fold16(input logic [15:0] acc,
                                         input logic [7:0]  din);
    logic [15:0] a;
    a = acc ^ {din, 8'h00}; // [R2]
    for (int i = 0; i < crceng_pkg::BitsPerByte; i++) begin // [R3]
      if (a[15]) begin
        a = {a[14:0], 1'b0} ^ crceng_pkg::Poly16; // [R1]
      end else begin
        a = {a[14:0], 1'b0};
      end
    end
    return a;
  endfunction

  // fold one byte into the 32-bit result, reflected
  function automatic logic [31:0] fold32(input logic [31:0] acc,
                                         input logic [7:0]  din);
    logic [31:0] a;
    a = acc ^ {24'h000000, din}; // [R5]
    for (int i = 0; i < crceng_pkg::BitsPerByte; i++) begin // [R6]
      if (a[0]) begin
        a = {1'b0, a[31:1]} ^ crceng_pkg::Poly32Refl; // [R4]
      end else begin
        a = {1'b0, a[31:1]};
      end
    end
    return a;
  endfunction

  // one byte into whichever width is selected
  function automatic logic [31:0] foldSel(input logic [31:0] acc,
                                          input logic [7:0]  din,
                                          input logic        w16);
    if (w16) begin
      return {16'h0000, fold16(acc[15:0], din)}; // [R8] [R16]
    end
    return fold32(acc, din); // [R8]
  endfunction

  // effective byte lane for a pointer value
  function automatic logic [1:0] laneOf(input logic [1:0] p,
                                        input logic       w16);
    return w16 ? {1'b0, p[0]} : p; // [R20]
  endfunction

  typedef enum logic [1:0] {AutoIdle, AutoRead, AutoFold} crceng_auto_type;

  logic [31:0]                     resultQ, resultD;   // crc accumulator
  logic [1:0]                      ptrQ;               // result pointer
  logic                            w16Q;               // width select
  logic                            onesQ;              // preset select
  logic [7:0]                      revQ;               // bit-reverse reg
  logic [7:0]                      rdByteQ;            // captured port byte
  crceng_auto_type                 stQ;                // flash walk state
  logic [crceng_pkg::CountW-1:0]   secLeftQ;           // sectors remaining
  logic [9:0]                      byteIdxQ;           // offset in sector
  logic [crceng_pkg::FlashAddrW-1:0] addrQ;            // flash address
  logic                            stallQ;
  logic                            reqValidQ;
  logic [1:0]                      lane;
  logic [31:0]                     preset;
  logic                            w16Eff;             // width in force

  assign lane   = laneOf(ptrQ, w16Q);
  // preset follows the select bit of the same control write
  assign preset = ctrlData.presetOnes ? crceng_pkg::PresetOnes
                                      : crceng_pkg::PresetZeros; // [R9]
  // a control write narrows the result in its own cycle, no stale half
  assign w16Eff = ctrlWr ? ctrlData.widthSel16 : w16Q; // [R16]

  // control fields; a write stores width and preset select, the pointer below
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      w16Q  <= crceng_pkg::WidthRst;
      onesQ <= crceng_pkg::PresetRst;
    end else if (ctrlWr) begin
      w16Q  <= ctrlData.widthSel16; // [R8]
      onesQ <= ctrlData.presetOnes; // [R9]
    end
  end

  // pointer: control write loads it, each data access bumps it
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ptrQ <= crceng_pkg::PtrRst;
    end else if (ctrlWr) begin
      ptrQ <= ctrlData.bytePtr;
    end else if (resultRd || resultWr) begin
      ptrQ <= ptrQ + 2'h1; // [R17] wraps 11 to 00
    end
  end

  // accumulator next value; priority preset, port write, flash, cpu byte
  always_comb begin
    resultD = resultQ; // [R18] hold otherwise
    if (ctrlWr && ctrlData.presetCmd) begin
      // uses select bits written in the same access
      resultD = preset; // [R10] [R7]
    end else if (resultWr) begin
      resultD[lane*8 +: 8] = resultWrData; // [R17]
    end else if (stQ == AutoFold) begin
      resultD = foldSel(resultQ, flashData, w16Q); // [R14]
    end else if (byteInWr) begin
      resultD = foldSel(resultQ, byteIn, w16Q); // [R11]
    end
    if (w16Eff) begin
      // 16-bit mode keeps only the low half, a preset included
      resultD[31:16] = 16'h0000; // [R16] narrow result in 16-bit mode
    end
  end

  // accumulator register
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      resultQ <= crceng_pkg::ResultRst;
    end else begin
      resultQ <= resultD;
    end
  end

  // data port read byte, captured on the read strobe
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rdByteQ <= crceng_pkg::ByteRst;
    end else if (resultRd) begin
      rdByteQ <= resultQ[lane*8 +: 8]; // [R17] [R20]
    end
  end

  // bit-reverse register stores the mirror so reads need no logic
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      revQ <= crceng_pkg::ByteRst;
    end else if (revWr) begin
      for (int i = 0; i < 8; i++) begin
        revQ[i] <= revData[7-i]; // [R19] [R21]
      end
    end
  end

  // flash walk: control write with auto enabled starts it;
  // one byte read then folded, two cycles per byte, cpu held meanwhile
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      stQ       <= AutoIdle;
      secLeftQ  <= '0;
      byteIdxQ  <= '0;
      addrQ     <= '0;
      stallQ    <= 1'b0;
      reqValidQ <= 1'b0;
    end else begin
      case (stQ)
        AutoIdle: begin
          // zero sectors: nothing to do, no stall
          if (ctrlWr && autoEnable && sectorCount != '0) begin // [R13]
            stQ       <= AutoRead;
            secLeftQ  <= sectorCount;
            byteIdxQ  <= '0;
            addrQ     <= crceng_pkg::FlashAddrW'({startPage, 9'h000});
            stallQ    <= 1'b1; // [R13]
            reqValidQ <= 1'b1;
          end
        end
        AutoRead: begin
          stQ       <= AutoFold; // flash data valid next cycle
          reqValidQ <= 1'b0;
        end
        AutoFold: begin
          addrQ <= addrQ + 1'b1; // consecutive sectors
          if (byteIdxQ == crceng_pkg::LastByteIdx) begin // [R14]
            byteIdxQ <= '0;
            secLeftQ <= secLeftQ - 1'b1;
            if (secLeftQ == 8'h01) begin
              stQ    <= AutoIdle;
              stallQ <= 1'b0;
            end else begin
              stQ       <= AutoRead;
              reqValidQ <= 1'b1;
            end
          end else begin
            byteIdxQ  <= byteIdxQ + 1'b1;
            stQ       <= AutoRead;
            reqValidQ <= 1'b1;
          end
        end
        default: begin
          stQ    <= AutoIdle;
          stallQ <= 1'b0;
        end
      endcase
    end
  end

  assign resultByte     = rdByteQ;
  assign bytePtr        = ptrQ;
  assign widthSel16     = w16Q;
  assign presetOnes     = onesQ;
  assign result         = resultQ;
  assign revOut         = revQ;
  assign cpuStall       = stallQ;
  assign flashReq.valid = reqValidQ;
  assign flashReq.addr  = addrQ;

  // 16-bit fold of one cpu byte lands next cycle
  a_fold16_byte: assert property (@(posedge clk) disable iff (!arst_n) // [R3]
    byteInWr && w16Q && !ctrlWr && !resultWr && stQ != AutoFold
    |=> resultQ == {16'h0000, fold16($past(resultQ[15:0]), $past(byteIn))})
    else $error("16-bit fold wrong");

  a_fold32_byte: assert property (@(posedge clk) disable iff (!arst_n) // [R6]
    byteInWr && !w16Q && !ctrlWr && !resultWr && stQ != AutoFold
    |=> resultQ == fold32($past(resultQ), $past(byteIn)))
    else $error("32-bit fold wrong");

  a_preset_value: assert property (@(posedge clk) disable iff (!arst_n) // [R10]
    ctrlWr && ctrlData.presetCmd
    |=> resultQ == (!$past(ctrlData.presetOnes) ? 32'h00000000
        : $past(ctrlData.widthSel16) ? 32'h0000ffff : 32'hffffffff))
    else $error("preset value wrong");

  a_result_hold: assert property (@(posedge clk) disable iff (!arst_n) // [R18]
    !ctrlWr && !resultWr && !byteInWr && stQ != AutoFold
    |=> $stable(resultQ))
    else $error("result changed without cause");

  a_ptr_advance: assert property (@(posedge clk) disable iff (!arst_n) // [R17]
    (resultRd || resultWr) && !ctrlWr |=> ptrQ == $past(ptrQ) + 2'h1)
    else $error("pointer did not advance");

  a_read_lane: assert property (@(posedge clk) disable iff (!arst_n) // [R20]
    resultRd && w16Q && ptrQ[1]
    |=> rdByteQ == $past(resultQ[ptrQ[0]*8 +: 8]))
    else $error("16-bit pointer wrap wrong");

  a_rev_mirror: assert property (@(posedge clk) disable iff (!arst_n) // [R21]
    revWr |=> $past(revData) == {revQ[0], revQ[1], revQ[2], revQ[3],
                                 revQ[4], revQ[5], revQ[6], revQ[7]})
    else $error("bit reverse wrong");

  a_auto_stall: assert property (@(posedge clk) disable iff (!arst_n) // [R13]
    stQ == AutoIdle && ctrlWr && autoEnable && sectorCount != '0
    |=> cpuStall ##1 cpuStall ##1 cpuStall)
    else $error("stall not raised by auto start");

  a_width_narrow: assert property (@(posedge clk) disable iff (!arst_n) // [R16]
    w16Q |-> resultQ[31:16] == 16'h0000)
    else $error("upper half set in 16-bit mode");
endmodule

// *** include/crceng_pkg.sv ***
// crceng_pkg: constants and carrier types of the byte-stream crc engine
// assumes a single 50 MHz clock domain and a cpu-side strobe interface
package crceng_pkg;
  localparam logic [15:0] Poly16      = 16'h1021;     // msb-first generator
  localparam logic [31:0] Poly32      = 32'h04c11db7; // normal form
  localparam logic [31:0] Poly32Refl  = 32'hedb88320; // reflected form
  localparam logic [31:0] PresetZeros = 32'h00000000;
  localparam logic [31:0] PresetOnes  = 32'hffffffff;
  localparam logic [31:0] ResultRst   = 32'h00000000; // result after reset
  localparam logic [1:0]  PtrRst      = 2'h0;         // pointer after reset
  localparam logic        WidthRst    = 1'b0;         // 32-bit after reset
  localparam logic        PresetRst   = 1'b0;         // zeros after reset
  localparam logic [7:0]  ByteRst     = 8'h00;
  localparam int          BitsPerByte = 8;
  localparam logic [9:0]  SectorBytes = 10'h200;      // 512 bytes a sector
  localparam logic [9:0]  LastByteIdx = 10'h1ff;
  localparam int          PageW       = 5;            // start page index
  localparam int          CountW      = 8;            // sector count width
  localparam int          FlashAddrW  = 14;           // 16 kB flash space
  localparam int          SectorShift = 9;

  // control write as software issues it
  typedef struct packed {
    logic       widthSel16; // 1 selects 16-bit, 0 selects 32-bit
    logic       presetCmd;  // 1 loads the preset
    logic       presetOnes; // 1 presets all ones
    logic [1:0] bytePtr;    // result byte pointer
  } crceng_ctrl_type;

  // flash read request toward the memory
  typedef struct packed {
    logic                  valid;
    logic [FlashAddrW-1:0] addr;
  } crceng_flash_req_type;
endpackage

// *** sim/crceng_flash_model.sv ***
// crceng_flash_model: behavioural flash that answers the engine's reads
// assumes one byte per request, data standing one cycle after it
`timescale 1ns/1ps
module crceng_flash_model (
  // clock
  input  wire logic                             clk,
  // read request and answer
  input  wire crceng_pkg::crceng_flash_req_type flashReq,
  output      logic [7:0]                       flashData
);
  // contents are a plain function of the address, easy to predict
  function automatic logic [7:0] fdat(input logic [13:0] a);
    return a[7:0] ^ {a[13:9], 3'h5};
  endfunction

  initial flashData = 8'h00;

  // answer one cycle on; otherwise toggle so stale data is never reused
  always @(posedge clk) begin
    if (flashReq.valid === 1'b1) begin
      flashData <= fdat(flashReq.addr);
    end else begin
      flashData <= ~flashData;
    end
  end
endmodule

// *** sim/crc_engine_16_32_test.sv ***
// crc_engine_16_32_test: self-checking bench of the byte-stream crc engine
// assumes crceng_top and the flash model; inputs move on the falling edge
`timescale 1ns/1ps
module crc_engine_16_32_test;
  logic        clk, arst_n, ctrlWr, byteInWr, resultRd, resultWr;
  logic        autoEnable, revWr, widthSel16, presetOnes, cpuStall;
  logic [7:0]  byteIn, resultWrData, revData, flashData, resultByte, revOut;
  logic [4:0]  startPage;
  logic [7:0]  sectorCount;
  logic [1:0]  bytePtr;
  logic [31:0] result, e;   // e: expected result
  logic [7:0]  d;           // last byte read
  logic [13:0] expA;        // next expected flash address
  int          errCount, totalChecks, cycles, nReq, nStall;
  crceng_pkg::crceng_ctrl_type      ctrlData;
  crceng_pkg::crceng_flash_req_type flashReq;

  crceng_top i_crceng_top (.clk, .arst_n, .ctrlWr, .ctrlData, .byteInWr,
    .byteIn, .resultRd, .resultWr, .resultWrData, .autoEnable, .startPage,
    .sectorCount, .flashData, .revWr, .revData, .resultByte, .bytePtr,
    .widthSel16, .presetOnes, .result, .revOut, .cpuStall, .flashReq);
  crceng_flash_model i_crceng_flash_model (.clk, .flashReq, .flashData);

  // bench copy of the flash contents
  function automatic logic [7:0] fdat(input logic [13:0] a);
    return a[7:0] ^ {a[13:9], 3'h5};
  endfunction
  // reference steps, written from the documented bit loops
  function automatic logic [31:0] c16(input logic [31:0] a, logic [7:0] b);
    logic [15:0] r;
    r = a[15:0] ^ {b, 8'h00};
    for (int i = 0; i < 8; i++)
      r = r[15] ? (r << 1) ^ crceng_pkg::Poly16 : r << 1;
    return {16'h0000, r};
  endfunction
  function automatic logic [31:0] c32(input logic [31:0] a, logic [7:0] b);
    a = a ^ {24'h000000, b};
    for (int i = 0; i < 8; i++)
      a = a[0] ? (a >> 1) ^ crceng_pkg::Poly32Refl : a >> 1;
    return a;
  endfunction

  // 20 ns clock
  initial clk = 1'b0;
  always #10 clk = ~clk;

  // hang guard, far above the ~2100 cycles the tests need
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      errCount++;
      $display("unexpected at %0t: timeout", $time);
      closeOut();
    end
  end

  // every flash request must walk consecutive addresses
  always @(negedge clk) begin
    if (flashReq.valid === 1'b1) begin
      chkWord({18'h0, flashReq.addr}, {18'h0, expA}, "flash addr");
      expA++;
      nReq++;
    end
  end

  task automatic chkWord(input logic [31:0] got, exp, input string m);
    totalChecks++;
    if (got !== exp) begin
      errCount++;
      $display("unexpected at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task automatic chkByte(input logic [7:0] got, exp, input string m);
    totalChecks++;
    if (got !== exp) begin
      errCount++;
      $display("unexpected at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  // one control write
  task automatic ctrl(input logic w16, init, ones, input logic [1:0] p);
    @(negedge clk);
    ctrlWr = 1'b1;
    ctrlData = '{w16, init, ones, p};
    @(negedge clk);
    ctrlWr = 1'b0;
  endtask
  // back-to-back input bytes; the expectation follows each one
  task automatic feed(input logic w16, input logic [7:0] q[$]);
    foreach (q[i]) begin
      @(negedge clk);
      byteInWr = 1'b1;
      byteIn = q[i];
      e = w16 ? c16(e, q[i]) : c32(e, q[i]);
    end
    @(negedge clk);
    byteInWr = 1'b0;
  endtask
  // data port read and write
  task automatic rdPort(output logic [7:0] v);
    @(negedge clk);
    resultRd = 1'b1;
    @(negedge clk);
    resultRd = 1'b0;
    v = resultByte;
  endtask
  task automatic wrPort(input logic [7:0] v);
    @(negedge clk);
    resultWr = 1'b1;
    resultWrData = v;
    @(negedge clk);
    resultWr = 1'b0;
  endtask

  task automatic closeOut();
    $display("checks %0d mismatches %0d", totalChecks, errCount);
    if (errCount == 0 && totalChecks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  initial begin
    {arst_n, ctrlWr, byteInWr, resultRd, resultWr, autoEnable, revWr} = '0;
    {byteIn, resultWrData, revData, startPage, sectorCount} = '0;
    ctrlData = '0;
    {errCount, totalChecks, cycles, nReq} = '0;
    repeat (2) @(negedge clk);
    arst_n = 1'b1;
    chkWord(result, crceng_pkg::ResultRst, "reset result");
    // 16-bit table values from an all-ones preset
    ctrl(1'b1, 1'b1, 1'b1, 2'h0);
    chkByte({7'h0, widthSel16}, 8'h01, "width bit");
    chkByte({7'h0, presetOnes}, 8'h01, "preset bit");
    chkWord(result, 32'h0000ffff, "preset16");
    e = 32'h0000ffff;
    feed(1'b1, {8'h63});
    chkWord(result, 32'h0000bd35, "crc16 one");
    ctrl(1'b1, 1'b1, 1'b1, 2'h0);
    e = 32'h0000ffff;
    feed(1'b1, {8'haa, 8'hbb, 8'hcc});
    chkWord(result, 32'h00006cf6, "crc16 three");
    for (int i = 0; i < 4; i++) begin
      rdPort(d);
      chkByte(d, i[0] ? 8'h6c : 8'hf6, "read16");
      chkByte({6'h0, bytePtr}, {6'h0, 2'(i + 1)}, "ptr16");
    end
    $display("test crc16 done");
    // 32-bit reflected table value, then all four lanes
    ctrl(1'b0, 1'b1, 1'b1, 2'h0);
    e = 32'hffffffff;
    feed(1'b0, {8'h00, 8'h00, 8'haa, 8'hbb, 8'hcc});
    chkWord(result, 32'h78d129bc, "crc32 five");
    for (int i = 0; i < 4; i++) begin
      rdPort(d);
      chkByte(d, e[8*i +: 8], "read32");
    end
    ctrl(1'b0, 1'b1, 1'b0, 2'h0);
    e = crceng_pkg::PresetZeros;
    chkWord(result, e, "preset zeros");
    chkByte({7'h0, presetOnes}, 8'h00, "zeros bit");
    feed(1'b0, {8'h63, 8'h5e});
    chkWord(result, e, "crc32 zeros");
    // a control write without preset leaves the result; port write lane 2
    ctrl(1'b0, 1'b0, 1'b0, 2'h2);
    chkWord(result, e, "no preset");
    wrPort(8'h5a);
    e[23:16] = 8'h5a;
    chkWord(result, e, "port write");
    chkByte({6'h0, bytePtr}, 8'h03, "ptr after write");
    repeat (5) @(negedge clk);
    chkWord(result, e, "held");
    $display("test port done");
    // bit reverse register
    for (int i = 0; i < 4; i++) begin
      @(negedge clk);
      revWr = 1'b1;
      revData = (8'h01 << (2 * i)) ^ 8'ha4;
      @(negedge clk);
      revWr = 1'b0;
      d = {revData[0], revData[1], revData[2], revData[3],
           revData[4], revData[5], revData[6], revData[7]};
      chkByte(revOut, d, "reverse");
    end
    $display("test reverse done");
    // automatic walk over sectors 3 and 4
    ctrl(1'b0, 1'b1, 1'b1, 2'h0);
    e = 32'hffffffff;
    startPage = 5'h03;
    autoEnable = 1'b1;
    sectorCount = 8'h02;
    expA = 14'h0600;
    nReq = 0;
    nStall = 0;
    ctrl(1'b0, 1'b0, 1'b1, 2'h0);
    // the stall is already up at the falling edge the start task ends on
    for (int i = 0; i < 5000; i++) begin
      if (cpuStall !== 1'b1) break;
      nStall++;
      @(negedge clk);
    end
    chkWord(32'(nStall), 32'd2048, "stall cycles");
    chkWord(32'(nReq), 32'd1024, "bytes read");
    for (int a = 1536; a < 2560; a++) e = c32(e, fdat(14'(a)));
    chkWord(result, e, "auto crc");
    sectorCount = 8'h00;
    ctrl(1'b0, 1'b0, 1'b1, 2'h0);
    repeat (2) @(negedge clk);
    chkByte({7'h0, cpuStall}, 8'h00, "zero count");
    autoEnable = 1'b0;
    rdPort(d);
    chkByte(d, e[7:0], "auto read");
    $display("test auto done");
    closeOut();
  end
endmodule
